// ---- hw/pug_regs.vh ----
`ifndef PUG_REGS_VH
`define PUG_REGS_VH
// Register window offsets (byte addresses within the register window).
`define PUG_CFG_IO_OFS 12'h800
`define PUG_EDGE_IRQ_OFS 12'h804
`define PUG_ENG_RST_OFS 12'h808
// Field positions of the configuration and user I/O word and of the edge interrupt word.
`define PUG_OUT_MSB 31
`define PUG_OUT_LSB 24
`define PUG_IN_MSB 23
`define PUG_IN_LSB 16
`define PUG_MEMSZ_BIT 11
`define PUG_EIRQ_FALL_EN_LSB 24
`define PUG_EIRQ_RISE_EN_LSB 16
`define PUG_EIRQ_FALL_ST_LSB 8
`define PUG_EIRQ_RISE_ST_LSB 0
// Constant fields and reset values.
`define PUG_CFG_CONST 5'h1f
`define PUG_ENG_ONE 3'h0
`define PUG_ENG_TWO 3'h1
`define PUG_OUT_RST 8'hff
`define PUG_ENG_RST_RST 1'h1
// Glitch filter time and clock period.
`define PUG_FILT_NS 90
`define PUG_CLK_NS 8
`define PUG_FILT_CYC ((`PUG_FILT_NS + `PUG_CLK_NS - 1) / `PUG_CLK_NS)
// Memory window geometry.
`define PUG_ENG_SEL_BIT 17
`define PUG_MEM_TOP_BIT 18
`endif

// ---- hw/pug_glue.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pug_regs.vh"

// Theory of operation.
// The PCI core decodes its two memory windows and hands this block plain strobes.
// The register window carries three 32-bit words: the configuration and user I/O
// word, the user input edge interrupt control and status word, and the engine
// reset word.
// Every register access is taken on the rising edge at which select and a strobe
// are high, the I/O space flag is low and the clock enable is high.
// Read data is registered, so it is loaded at the taking edge itself and
// holds until the next read.
// Unmapped offsets read zero and ignore writes, so a stray access does no harm.
// An I/O space cycle is never claimed and changes no state.
//
// User inputs are treated as synchronous to the clock.
// Each one passes a level filter: a new level must stand for the full filter
// time before the filtered level follows it.
// Pulses shorter than that never reach the edge detectors.
// The edge detectors compare the filtered level with its value one cycle earlier.
// A detected edge sets its status flag only while its enable is one.
// A status flag stays set until software writes a one to it.
// When an edge and a clear fall in the same cycle the edge wins, so no event is
// ever lost between a status read and the clear that follows it.
//
// The user outputs are open drain.
// A zero in the output field pulls the pin low; a one releases it to the pull-up.
// Reset loads all ones, so no pin is driven after reset.
//
// The engine reset word holds both engines in reset while its bit is zero.
// It is meant for testing only; in normal use it stays one.
//
// The memory window maps each engine's word memory at twice its word address.
// Byte address bit 17 picks the engine and bits 16 down to 1 give the word.
// The upper half of the window is reserved and is not claimed.
// Only word transfers are meaningful there; the host must not use byte or
// doubleword accesses.
//
// The interrupt line is open drain as well: its enable goes high while any
// engine interrupt or any pending user edge flag is present.
//
// The terminal address is either tracked every cycle or captured on a command
// strobe, as the latch-select input asks.
//
// A low clock enable freezes every flip-flop of the block.

module pug_glue #(
  parameter MEM_IS_4K = 1'b0,
  parameter TWO_ENGINES = 1'b1
) (
  // Clock, reset and enable.
  input wire mclk_in,
  input wire reset_n_in,
  input wire clk_en_in,
  // Register window access, decoded by the PCI core.
  input wire reg_sel_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire is_io_space_in,
  input wire [11:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire [3:0] reg_be_in,
  output reg [31:0] reg_rdata_out,
  // Memory window access, decoded by the PCI core.
  input wire mem_sel_in,
  input wire mem_wr_in,
  input wire mem_rd_in,
  input wire [18:0] mem_addr_in,
  input wire [15:0] mem_wdata_in,
  output wire mem_claim_out,
  output reg [15:0] mem_rdata_out,
  // Engine side.
  output wire [1:0] eng_cs_n_out,
  output wire eng_wr_out,
  output wire eng_rd_out,
  output wire [15:0] eng_addr_out,
  output wire [15:0] eng_wdata_out,
  input wire [15:0] eng0_rdata_in,
  input wire [15:0] eng1_rdata_in,
  input wire [1:0] eng_irq_n_in,
  output wire eng_reset_n_out,
  output wire eng_buffered_mode_out,
  output wire eng_16bit_mode_out,
  // Terminal address straps.
  input wire [4:0] terminal_address_bits_in,
  input wire terminal_address_parity_in,
  input wire terminal_address_latch_select_in,
  input wire ta_latch_cmd_in,
  output reg [4:0] ta_bits_out,
  output reg ta_parity_out,
  // User pins.
  input wire [7:0] user_in,
  output wire [7:0] user_out,
  output wire [7:0] user_oe_out,
  // PCI interrupt pin, open drain.
  output wire inta_out,
  output wire inta_oe_out
);

  // Filter length in clock cycles, cut to the counter width on purpose.
  localparam integer FILT_CYC_INT = `PUG_FILT_CYC;
  localparam [3:0] FILT_CYC = FILT_CYC_INT[3:0];

  // Output field of the configuration word; one releases a pin.
  reg [7:0] out_reg;
  // Edge enables and edge status flags.
  reg [7:0] fall_en;
  reg [7:0] rise_en;
  reg [7:0] fall_st;
  reg [7:0] rise_st;
  // Engine reset bit; zero holds both engines in reset.
  reg eng_rst;
  // Filtered user levels and their values one cycle earlier.
  reg [7:0] filt;
  reg [7:0] filt_q;
  // Per-input count of cycles that the raw level has differed.
  reg [3:0] filt_cnt [0:7];
  wire reg_wr;
  wire user_pend;
  wire eng_irq;
  wire [7:0] rise_ev;
  wire [7:0] fall_ev;
  wire [31:0] cfg_word;
  wire [31:0] eirq_word;
  integer i;

  // Byte-lane merge of a write into a 32-bit word.
  function [31:0] pug_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer k;
    begin
      pug_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          pug_merge[k*8 +: 8] = wd[k*8 +: 8];
        end
      end
    end
  endfunction

  // Register writes count only in memory space.
  assign reg_wr = reg_sel_in & reg_wr_in & ~is_io_space_in;

  // Filter: the stable level replaces the filtered one after FILT_CYC cycles.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      filt <= 8'h00;
      filt_q <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        filt_cnt[i] <= 4'h0;
      end
    end else if (clk_en_in) begin
      filt_q <= filt;
      for (i = 0; i < 8; i = i + 1) begin
        if (user_in[i] == filt[i]) begin
          filt_cnt[i] <= 4'h0;
        end else if (filt_cnt[i] == FILT_CYC - 4'h1) begin
          filt[i] <= user_in[i];
          filt_cnt[i] <= 4'h0;
        end else begin
          filt_cnt[i] <= filt_cnt[i] + 4'h1;
        end
      end
    end
  end

  // Edges of the filtered level, gated by their enables.
  assign rise_ev = filt & ~filt_q & rise_en;
  assign fall_ev = ~filt & filt_q & fall_en;

  // Control and status registers; an edge wins over a clear.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_reg <= `PUG_OUT_RST;
      fall_en <= 8'h00;
      rise_en <= 8'h00;
      fall_st <= 8'h00;
      rise_st <= 8'h00;
      eng_rst <= `PUG_ENG_RST_RST;
    end else if (clk_en_in) begin
      fall_st <= fall_st | fall_ev;
      rise_st <= rise_st | rise_ev;
      if (reg_wr && reg_addr_in == `PUG_CFG_IO_OFS && reg_be_in[3]) begin
        out_reg <= reg_wdata_in[`PUG_OUT_MSB:`PUG_OUT_LSB];
      end
      if (reg_wr && reg_addr_in == `PUG_EDGE_IRQ_OFS) begin
        if (reg_be_in[3]) begin
          fall_en <= reg_wdata_in[31:24];
        end
        if (reg_be_in[2]) begin
          rise_en <= reg_wdata_in[23:16];
        end
        if (reg_be_in[1]) begin
          fall_st <= (fall_st & ~reg_wdata_in[15:8]) | fall_ev;
        end
        if (reg_be_in[0]) begin
          rise_st <= (rise_st & ~reg_wdata_in[7:0]) | rise_ev;
        end
      end
      if (reg_wr && reg_addr_in == `PUG_ENG_RST_OFS && reg_be_in[0]) begin
        eng_rst <= reg_wdata_in[0];
      end
    end
  end

  // Interrupt summaries.
  assign user_pend = |{fall_st, rise_st};
  assign eng_irq = ~&eng_irq_n_in;
  assign inta_out = 1'b0;
  assign inta_oe_out = user_pend | eng_irq;

  // Read words.
  assign cfg_word = {out_reg, user_in, 4'h0, MEM_IS_4K,
    (TWO_ENGINES ? `PUG_ENG_TWO : `PUG_ENG_ONE),
    `PUG_CFG_CONST, ~user_pend, eng_irq_n_in};
  assign eirq_word = {fall_en, rise_en, fall_st, rise_st};

  // Registered read data; unmapped offsets read zero.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (clk_en_in) begin
      if (reg_sel_in && reg_rd_in && !is_io_space_in) begin
        case (reg_addr_in)
          `PUG_CFG_IO_OFS: reg_rdata_out <= cfg_word;
          `PUG_EDGE_IRQ_OFS: reg_rdata_out <= eirq_word;
          `PUG_ENG_RST_OFS: reg_rdata_out <= {31'h00000000, eng_rst};
          default: reg_rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // Open-drain user outputs: a zero bit pulls the pin low.
  assign user_out = 8'h00;
  assign user_oe_out = ~out_reg;

  // Engine control straps.
  assign eng_reset_n_out = eng_rst;
  assign eng_buffered_mode_out = 1'b1;
  assign eng_16bit_mode_out = 1'b1;

  // Memory window: word address is byte address over two.
  assign mem_claim_out = mem_sel_in & ~is_io_space_in & ~mem_addr_in[`PUG_MEM_TOP_BIT];
  assign eng_cs_n_out[0] = ~(mem_claim_out & ~mem_addr_in[`PUG_ENG_SEL_BIT]);
  assign eng_cs_n_out[1] = ~(mem_claim_out & mem_addr_in[`PUG_ENG_SEL_BIT]);
  assign eng_addr_out = mem_addr_in[16:1];
  assign eng_wdata_out = mem_wdata_in;
  assign eng_wr_out = mem_claim_out & mem_wr_in;
  assign eng_rd_out = mem_claim_out & mem_rd_in;

  // Registered memory read data from the selected engine.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_rdata_out <= 16'h0000;
    end else if (clk_en_in && eng_rd_out) begin
      mem_rdata_out <= mem_addr_in[`PUG_ENG_SEL_BIT] ? eng1_rdata_in : eng0_rdata_in;
    end
  end

  // Terminal address: tracked, or captured on command.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ta_bits_out <= 5'h00;
      ta_parity_out <= 1'b0;
    end else if (clk_en_in) begin
      if (!terminal_address_latch_select_in || ta_latch_cmd_in) begin
        ta_bits_out <= terminal_address_bits_in;
        ta_parity_out <= terminal_address_parity_in;
      end
    end
  end

endmodule // pug_glue
`default_nettype wire

// ---- tb/pug_glue_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// Watches the glue's ports for register, window and interrupt behaviour.
module pug_chk #(
  parameter MEM_IS_4K = 1'b0,
  parameter TWO_ENGINES = 1'b1
) (
  // Observed ports.
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic is_io_space_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic mem_sel_in,
  input wire logic [18:0] mem_addr_in,
  input wire logic mem_claim_out,
  input wire logic [15:0] eng_addr_out,
  input wire logic [1:0] eng_irq_n_in,
  input wire logic eng_reset_n_out,
  input wire logic inta_oe_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // Register accesses in the form the glue takes them.
  wire acc = reg_sel_in && !is_io_space_in && clk_en_in;
  wire rd_cfg = acc && reg_rd_in && reg_addr_in == 12'h800;
  wire wr_rst = acc && reg_wr_in && reg_addr_in == 12'h808;
  AST_CFG_CONST: assert property (rd_cfg |=> reg_rdata_out[15:12] == 4'h0 && reg_rdata_out[7:3] == 5'h1f)
    else $error("config constant bits wrong");
  AST_CFG_SIZE: assert property (rd_cfg |=> reg_rdata_out[11] == MEM_IS_4K)
    else $error("memory size bit wrong");
  AST_CFG_COUNT: assert property (rd_cfg |=> reg_rdata_out[10:8] == {2'h0, TWO_ENGINES})
    else $error("engine count wrong");
  AST_CFG_ENG_IRQ: assert property (rd_cfg |=> reg_rdata_out[1:0] == $past(eng_irq_n_in))
    else $error("engine interrupt bits wrong");
  AST_NO_IO: assert property (is_io_space_in |-> !mem_claim_out)
    else $error("io cycle claimed");
  AST_MEM_MAP: assert property (mem_sel_in && !is_io_space_in |->
    mem_claim_out == !mem_addr_in[18] && eng_addr_out == mem_addr_in[16:1])
    else $error("memory window map wrong");
  AST_INTA: assert property (eng_irq_n_in != 2'h3 |-> inta_oe_out)
    else $error("interrupt line not asserted");
  AST_RST_HOLD: assert property (!eng_reset_n_out && !wr_rst |=> !eng_reset_n_out)
    else $error("engine reset released unasked");
  // Main scenarios.
  COV_CFG: cover property (rd_cfg);
  COV_CLAIM: cover property (mem_claim_out);
  COV_INTA: cover property (inta_oe_out);
endmodule // pug_chk
bind pug_glue pug_chk #(.MEM_IS_4K(MEM_IS_4K), .TWO_ENGINES(TWO_ENGINES)) chk (.mclk_in,
  .reset_n_in, .clk_en_in, .reg_sel_in, .reg_wr_in, .reg_rd_in, .is_io_space_in, .reg_addr_in,
  .reg_rdata_out, .mem_sel_in, .mem_addr_in, .mem_claim_out, .eng_addr_out, .eng_irq_n_in,
  .eng_reset_n_out, .inta_oe_out);
`default_nettype wire

// ---- tb/pug_eng_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two protocol engines, each with a few words of shared memory.
module pug_eng_model (
  // Engine bus from the glue.
  input wire logic mclk_in,
  input wire logic [1:0] eng_cs_n_in,
  input wire logic eng_wr_in,
  input wire logic [15:0] eng_addr_in,
  input wire logic [15:0] eng_wdata_in,
  // Read data back to the glue.
  output logic [15:0] eng0_rdata_out,
  output logic [15:0] eng1_rdata_out
);
  logic [15:0] mem0 [0:15];
  logic [15:0] mem1 [0:15];
  // Word writes land only in the selected engine.
  always @(posedge mclk_in) begin
    if (eng_wr_in && !eng_cs_n_in[0]) mem0[eng_addr_in[3:0]] <= eng_wdata_in;
    if (eng_wr_in && !eng_cs_n_in[1]) mem1[eng_addr_in[3:0]] <= eng_wdata_in;
  end
  // An unselected engine shows the inverse word, so a stale value cannot pass.
  assign eng0_rdata_out = eng_cs_n_in[0] ? ~mem0[eng_addr_in[3:0]] : mem0[eng_addr_in[3:0]];
  assign eng1_rdata_out = eng_cs_n_in[1] ? ~mem1[eng_addr_in[3:0]] : mem1[eng_addr_in[3:0]];
endmodule // pug_eng_model
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module testbench;
  logic mclk_in = '0, reset_n_in = '0, clk_en_in = '1, reg_sel_in = '0, reg_wr_in = '0;
  logic reg_rd_in = '0, is_io_space_in = '0, mem_sel_in = '0, mem_wr_in = '0, mem_rd_in = '0;
  logic ta_latch_cmd_in = '0, terminal_address_parity_in = '0, terminal_address_latch_select_in = '1;
  logic [11:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out;
  logic [3:0] reg_be_in = '1;
  logic [18:0] mem_addr_in = '0;
  logic [15:0] mem_wdata_in = '0, mem_rdata_out, eng_addr_out, eng_wdata_out, eng0_rdata_in, eng1_rdata_in;
  logic [1:0] eng_cs_n_out, eng_irq_n_in = '1;
  logic [4:0] terminal_address_bits_in = '0, ta_bits_out;
  logic [7:0] user_in = '0, user_out, user_oe_out;
  logic mem_claim_out, eng_wr_out, eng_rd_out, eng_reset_n_out, eng_buffered_mode_out;
  logic eng_16bit_mode_out, ta_parity_out, inta_out, inta_oe_out;
  int fails = 0, check_count = 0, cyc = 0;
  pug_glue dut (.mclk_in, .reset_n_in, .clk_en_in, .reg_sel_in, .reg_wr_in, .reg_rd_in,
    .is_io_space_in, .reg_addr_in, .reg_wdata_in, .reg_be_in, .reg_rdata_out, .mem_sel_in,
    .mem_wr_in, .mem_rd_in, .mem_addr_in, .mem_wdata_in, .mem_claim_out, .mem_rdata_out,
    .eng_cs_n_out, .eng_wr_out, .eng_rd_out, .eng_addr_out, .eng_wdata_out, .eng0_rdata_in,
    .eng1_rdata_in, .eng_irq_n_in, .eng_reset_n_out, .eng_buffered_mode_out, .eng_16bit_mode_out,
    .terminal_address_bits_in, .terminal_address_parity_in, .terminal_address_latch_select_in,
    .ta_latch_cmd_in, .ta_bits_out, .ta_parity_out, .user_in, .user_out, .user_oe_out,
    .inta_out, .inta_oe_out);
  pug_eng_model eng (.mclk_in, .eng_cs_n_in(eng_cs_n_out), .eng_wr_in(eng_wr_out),
    .eng_addr_in(eng_addr_out), .eng_wdata_in(eng_wdata_out), .eng0_rdata_out(eng0_rdata_in),
    .eng1_rdata_out(eng1_rdata_in));
  // Clock and hang guard.
  always #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One register access, strobe held for exactly one taking edge.
  task reg_op(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk_in);
    {reg_sel_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, reg_be_in} <= {1'h1, w, !w, a, d, be};
    @(posedge mclk_in);
    {reg_sel_in, reg_wr_in, reg_rd_in} <= 3'h0;
    #1;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    reg_op(1'h0, a, 32'h0, 4'hf);
    `CHK(reg_rdata_out, e)
  endtask
  // One word access to the engine memory window.
  task mem_op(input logic w, input logic [18:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    {mem_sel_in, mem_wr_in, mem_rd_in, mem_addr_in, mem_wdata_in} <= {1'h1, w, !w, a, d};
    @(posedge mclk_in);
    {mem_sel_in, mem_wr_in, mem_rd_in} <= 3'h0;
    #1;
  endtask
  task t_reset_outputs;
    rd(12'h800, 32'hff0001ff);
    rd(12'h804, 32'h0);
    rd(12'h808, 32'h1);
    rd(12'h80c, 32'h0);
    reg_op(1'h1, 12'h800, 32'h5a00ffff, 4'h8);
    `CHK(user_oe_out, 8'ha5)
    rd(12'h800, 32'h5a0001ff);
    reg_op(1'h1, 12'h800, 32'hff000000, 4'hf);
  endtask
  task t_edges;
    reg_op(1'h1, 12'h804, 32'h06050000, 4'hf);
    @(posedge mclk_in) user_in <= 8'h07;
    repeat (20) @(posedge mclk_in);
    rd(12'h804, 32'h06050005);
    rd(12'h800, 32'hff0701fb);
    `CHK(inta_oe_out, 1'h1)
    @(posedge mclk_in) user_in <= 8'h00;
    repeat (20) @(posedge mclk_in);
    rd(12'h804, 32'h06050605);
    reg_op(1'h1, 12'h804, 32'h06050005, 4'hf);
    rd(12'h804, 32'h06050600);
    reg_op(1'h1, 12'h804, 32'h06050600, 4'hf);
    @(posedge mclk_in) user_in <= 8'h01;
    repeat (5) @(posedge mclk_in);
    user_in <= 8'h00;
    repeat (20) @(posedge mclk_in);
    rd(12'h804, 32'h06050000);
    `CHK(inta_oe_out, 1'h0)
  endtask
  task t_eng_reset;
    reg_op(1'h1, 12'h808, 32'h0, 4'hf);
    rd(12'h808, 32'h0);
    @(posedge mclk_in) is_io_space_in <= 1'h1;
    reg_op(1'h1, 12'h808, 32'h1, 4'hf);
    `CHK(eng_reset_n_out, 1'h0)
    @(posedge mclk_in) is_io_space_in <= 1'h0;
    reg_op(1'h1, 12'h808, 32'h1, 4'hf);
    `CHK(eng_reset_n_out, 1'h1)
  endtask
  task t_mem_irq;
    mem_op(1'h1, 19'h20004, 16'h1234);
    mem_op(1'h1, 19'h00004, 16'h5678);
    mem_op(1'h0, 19'h20004, 16'h0);
    `CHK(mem_rdata_out, 16'h1234)
    mem_op(1'h0, 19'h00004, 16'h0);
    `CHK(mem_rdata_out, 16'h5678)
    @(posedge mclk_in) eng_irq_n_in <= 2'h2;
    rd(12'h800, 32'hff0001fe);
    `CHK(inta_oe_out, 1'h1)
    @(posedge mclk_in) eng_irq_n_in <= 2'h3;
  endtask
  // Reset in mid-run clears the edge register and restores the engine reset bit.
  task t_mid_reset;
    reg_op(1'h1, 12'h804, 32'hff000000, 4'hf);
    reg_op(1'h1, 12'h808, 32'h0, 4'hf);
    @(posedge mclk_in) reset_n_in <= 1'h0;
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'h1;
    #1;
    `CHK(eng_reset_n_out, 1'h1)
    rd(12'h804, 32'h0);
    rd(12'h808, 32'h1);
  endtask
  task t_term_addr;
    @(posedge mclk_in) {terminal_address_bits_in, terminal_address_parity_in, ta_latch_cmd_in} <= 7'h2b;
    @(posedge mclk_in) {terminal_address_bits_in, ta_latch_cmd_in} <= 6'h2a;
    @(posedge mclk_in) #1;
    `CHK({ta_parity_out, ta_bits_out}, 6'h2a)
    @(posedge mclk_in) terminal_address_latch_select_in <= 1'h0;
    repeat (2) @(posedge mclk_in);
    #1;
    `CHK({ta_parity_out, ta_bits_out}, 6'h35)
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'h1;
    t_reset_outputs;
    t_edges;
    t_eng_reset;
    t_mem_irq;
    t_mid_reset;
    t_term_addr;
    end_sim;
  end
endmodule // testbench
`default_nettype wire
